// file: hdl/bit_sync.sv
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule
`default_nettype wire

// file: hdl/pixel_route.sv
`default_nettype none
module pixel_route (
    // configuration
    input  wire logic [2:0]   mode,
    input  wire logic         swap,
    input  wire logic [1:0]   sd_fmt,
    input  wire logic         sd_rgb,
    input  wire logic         hd_422,
    input  wire logic         hd_rgb,
    // synchronised buses
    input  wire logic [7:0]   sd_bus,
    input  wire logic [7:0]   luma_bus,
    input  wire logic [7:0]   chroma_bus,
    // routed result
    output vpi_pkg::fmt_t     fmt,
    output logic [7:0]        ch0,
    output logic [7:0]        ch1,
    output logic [7:0]        ch2,
    output logic              ddr,
    output logic              ext_only,
    output logic              use_sd_sync
);
    always_comb begin
        fmt         = vpi_pkg::FMT_NONE;
        ch0         = '0;
        ch1         = '0;
        ch2         = '0;
        ddr         = 1'b0;
        ext_only    = 1'b0;
        use_sd_sync = 1'b0;
        case (mode)
            vpi_pkg::MODE_SD: begin
                use_sd_sync = 1'b1;
                if (sd_rgb) begin
                    fmt      = vpi_pkg::FMT_SD_RGB;
                    ch0      = sd_bus;
                    ch1      = luma_bus;
                    ch2      = chroma_bus;
                    ext_only = 1'b1;
                end else if (sd_fmt[0]) begin
                    fmt      = vpi_pkg::FMT_SD_YC16;
                    ch0      = swap ? luma_bus : sd_bus;
                    ch1      = swap ? chroma_bus : luma_bus;
                    ext_only = 1'b1;
                end else begin
                    fmt = vpi_pkg::FMT_SD_YC8;
                    ch0 = swap ? luma_bus : sd_bus;
                end
            end
            vpi_pkg::MODE_HD_SDR: begin
                if (hd_rgb) begin
                    fmt = vpi_pkg::FMT_HD_RGB;
                    ch0 = sd_bus;
                    ch1 = luma_bus;
                    ch2 = chroma_bus;
                end else if (hd_422) begin
                    fmt = vpi_pkg::FMT_HD_YC16;
                    ch0 = luma_bus;
                    ch1 = chroma_bus;
                end else begin
                    fmt = vpi_pkg::FMT_HD_YC444;
                    ch0 = luma_bus;
                    ch1 = sd_bus;
                    ch2 = chroma_bus;
                end
            end
            vpi_pkg::MODE_HD_DDR: begin
                // rgb has no dual-rate form, so the stream is refused
                fmt = hd_rgb ? vpi_pkg::FMT_REFUSED : vpi_pkg::FMT_HD_DDR8;
                ddr = !hd_rgb;
                ch0 = luma_bus;
            end
            vpi_pkg::MODE_ED54: begin
                fmt = vpi_pkg::FMT_ED54;
                ch0 = luma_bus;
            end
            default: begin
                // simultaneous modes and reserved codes all idle with no format
                fmt = vpi_pkg::FMT_NONE;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: hdl/video_pixel_input_router.sv
`default_nettype none
module video_pixel_input_router (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // video source pins
    input  wire logic       primary_clock_input,
    input  wire logic [7:0] sd_pixel_bus,
    input  wire logic [7:0] luma_pixel_bus,
    input  wire logic [7:0] chroma_pixel_bus,
    input  wire logic       sd_hsync_n,
    input  wire logic       sd_vsync_n,
    input  wire logic       prog_hsync_n,
    input  wire logic       prog_vsync_n,
    input  wire logic       prog_blank_n,
    // captured pixel stream
    output logic            pix_valid,
    output logic      [7:0] pix_ch0,
    output logic      [7:0] pix_ch1,
    output logic      [7:0] pix_ch2,
    output vpi_pkg::fmt_t   pix_fmt,
    output logic            pix_hsync_n,
    output logic            pix_vsync_n,
    output logic            pix_blank_n,
    output logic            ext_sync_only
);
    localparam int PIN_W = 30;

    typedef enum {PH_WAIT_Y, PH_WAIT_C} phase_t;

    // configuration
    logic [2:0] mode;
    logic       swap;
    logic [1:0] edge_sel;
    logic       hd_422;
    logic       hd_rgb;
    logic       sd_rgb;
    logic [1:0] sd_fmt;
    logic [2:0] next_mode;
    logic       next_swap;
    logic [1:0] next_edge_sel;
    logic       next_hd_422;
    logic       next_hd_rgb;
    logic       next_sd_rgb;
    logic [1:0] next_sd_fmt;
    logic [7:0] next_reg_rdata;

    // pin side
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic             pclk_s;
    logic             pclk_d;
    logic             next_pclk_d;
    logic [7:0]       sd_s;
    logic [7:0]       luma_s;
    logic [7:0]       chroma_s;
    logic             shs_s;
    logic             svs_s;
    logic             phs_s;
    logic             pvs_s;
    logic             pbl_s;
    logic             pclk_rise;
    logic             pclk_fall;

    // routing
    vpi_pkg::fmt_t rt_fmt;
    logic [7:0]    rt_ch0;
    logic [7:0]    rt_ch1;
    logic [7:0]    rt_ch2;
    logic          rt_ddr;
    logic          rt_ext;
    logic          rt_sd_sync;
    logic          sel_hs;
    logic          sel_vs;
    logic          sel_bl;
    logic          y_on_rise;
    logic          sdr_cap;
    logic          y_cap;
    logic          c_cap;

    // capture state
    phase_t        phase;
    phase_t        next_phase;
    logic [7:0]    y_hold;
    logic [7:0]    next_y_hold;
    logic [2:0]    sync_hold;
    logic [2:0]    next_sync_hold;
    logic          next_pix_valid;
    logic [7:0]    next_pix_ch0;
    logic [7:0]    next_pix_ch1;
    logic [7:0]    next_pix_ch2;
    vpi_pkg::fmt_t next_pix_fmt;
    logic          next_pix_hsync_n;
    logic          next_pix_vsync_n;
    logic          next_pix_blank_n;
    logic          next_ext_sync_only;

    // register file
    always_comb begin
        next_mode      = mode;
        next_swap      = swap;
        next_edge_sel  = edge_sel;
        next_hd_422    = hd_422;
        next_hd_rgb    = hd_rgb;
        next_sd_rgb    = sd_rgb;
        next_sd_fmt    = sd_fmt;
        next_reg_rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                vpi_pkg::ADDR_INPUT_MODE: begin
                    next_mode     = reg_wdata[vpi_pkg::MODE_LSB +: 3];
                    next_swap     = reg_wdata[vpi_pkg::SWAP_BIT];
                    next_edge_sel = reg_wdata[vpi_pkg::EDGE_LSB +: 2];
                end
                vpi_pkg::ADDR_HD_FORMAT: next_hd_422 = reg_wdata[vpi_pkg::HD_422_BIT];
                vpi_pkg::ADDR_HD_CTRL:   next_hd_rgb = reg_wdata[vpi_pkg::HD_RGB_BIT];
                vpi_pkg::ADDR_SD_RGB:    next_sd_rgb = reg_wdata[vpi_pkg::SD_RGB_BIT];
                vpi_pkg::ADDR_SD_FORMAT: next_sd_fmt = reg_wdata[vpi_pkg::SD_FMT_LSB +: 2];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                vpi_pkg::ADDR_INPUT_MODE: begin
                    next_reg_rdata[vpi_pkg::MODE_LSB +: 3] = mode;
                    next_reg_rdata[vpi_pkg::SWAP_BIT]      = swap;
                    next_reg_rdata[vpi_pkg::EDGE_LSB +: 2] = edge_sel;
                end
                vpi_pkg::ADDR_HD_FORMAT: next_reg_rdata[vpi_pkg::HD_422_BIT] = hd_422;
                vpi_pkg::ADDR_HD_CTRL:   next_reg_rdata[vpi_pkg::HD_RGB_BIT] = hd_rgb;
                vpi_pkg::ADDR_SD_RGB:    next_reg_rdata[vpi_pkg::SD_RGB_BIT] = sd_rgb;
                vpi_pkg::ADDR_SD_FORMAT: next_reg_rdata[vpi_pkg::SD_FMT_LSB +: 2] = sd_fmt;
                vpi_pkg::ADDR_STATUS: begin
                    next_reg_rdata[3:0]               = pix_fmt;
                    next_reg_rdata[vpi_pkg::STAT_EXT] = ext_sync_only;
                    next_reg_rdata[vpi_pkg::STAT_REF] = (pix_fmt == vpi_pkg::FMT_REFUSED);
                end
                default: next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode      <= vpi_pkg::RST_MODE;
            swap      <= vpi_pkg::RST_BIT;
            edge_sel  <= vpi_pkg::RST_EDGE;
            hd_422    <= vpi_pkg::RST_BIT;
            hd_rgb    <= vpi_pkg::RST_BIT;
            sd_rgb    <= vpi_pkg::RST_BIT;
            sd_fmt    <= vpi_pkg::RST_SD_FMT;
            reg_rdata <= '0;
        end else begin
            mode      <= next_mode;
            swap      <= next_swap;
            edge_sel  <= next_edge_sel;
            hd_422    <= next_hd_422;
            hd_rgb    <= next_hd_rgb;
            sd_rgb    <= next_sd_rgb;
            sd_fmt    <= next_sd_fmt;
            reg_rdata <= next_reg_rdata;
        end
    end

    // the source clock is only sampled: pixel rate must stay well below half of ref_clk
    assign pins_raw = {primary_clock_input, sd_pixel_bus, luma_pixel_bus, chroma_pixel_bus,
                       sd_hsync_n, sd_vsync_n, prog_hsync_n, prog_vsync_n, prog_blank_n};

    bit_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign {pclk_s, sd_s, luma_s, chroma_s, shs_s, svs_s, phs_s, pvs_s, pbl_s} = pins_s;
    assign pclk_rise = pclk_s & ~pclk_d;
    assign pclk_fall = ~pclk_s & pclk_d;

    pixel_route u_route (
        .mode        (mode),
        .swap        (swap),
        .sd_fmt      (sd_fmt),
        .sd_rgb      (sd_rgb),
        .hd_422      (hd_422),
        .hd_rgb      (hd_rgb),
        .sd_bus      (sd_s),
        .luma_bus    (luma_s),
        .chroma_bus  (chroma_s),
        .fmt         (rt_fmt),
        .ch0         (rt_ch0),
        .ch1         (rt_ch1),
        .ch2         (rt_ch2),
        .ddr         (rt_ddr),
        .ext_only    (rt_ext),
        .use_sd_sync (rt_sd_sync)
    );

    // ED timing covers 525p and 625p only; line counts are not policed here
    assign sel_hs = rt_sd_sync ? shs_s : phs_s;
    assign sel_vs = rt_sd_sync ? svs_s : pvs_s;
    assign sel_bl = rt_sd_sync ? 1'b1 : pbl_s;

    assign y_on_rise = (edge_sel == vpi_pkg::EDGE_Y_RISE);
    assign sdr_cap   = pclk_rise && !rt_ddr && (rt_fmt != vpi_pkg::FMT_NONE)
                       && (rt_fmt != vpi_pkg::FMT_REFUSED);
    assign y_cap     = rt_ddr && (y_on_rise ? pclk_rise : pclk_fall);
    assign c_cap     = rt_ddr && (y_on_rise ? pclk_fall : pclk_rise);

    // capture and dual-rate pairing
    always_comb begin
        next_pclk_d        = pclk_s;
        next_phase         = phase;
        next_y_hold        = y_hold;
        next_sync_hold     = sync_hold;
        next_pix_valid     = 1'b0;
        next_pix_ch0       = pix_ch0;
        next_pix_ch1       = pix_ch1;
        next_pix_ch2       = pix_ch2;
        next_pix_hsync_n   = pix_hsync_n;
        next_pix_vsync_n   = pix_vsync_n;
        next_pix_blank_n   = pix_blank_n;
        next_pix_fmt       = rt_fmt;
        next_ext_sync_only = rt_ext;
        if (!rt_ddr) begin
            next_phase = PH_WAIT_Y;
            if (sdr_cap) begin
                next_pix_valid   = 1'b1;
                next_pix_ch0     = rt_ch0;
                next_pix_ch1     = rt_ch1;
                next_pix_ch2     = rt_ch2;
                next_pix_hsync_n = sel_hs;
                next_pix_vsync_n = sel_vs;
                next_pix_blank_n = sel_bl;
            end
        end else begin
            case (phase)
                PH_WAIT_Y: begin
                    if (y_cap) begin
                        next_y_hold    = rt_ch0;
                        next_sync_hold = {sel_hs, sel_vs, sel_bl};
                        next_phase     = PH_WAIT_C;
                    end
                end
                PH_WAIT_C: begin
                    if (c_cap) begin
                        next_pix_valid   = 1'b1;
                        next_pix_ch0     = y_hold;
                        next_pix_ch1     = rt_ch0;
                        next_pix_ch2     = '0;
                        next_pix_hsync_n = sync_hold[2];
                        next_pix_vsync_n = sync_hold[1];
                        next_pix_blank_n = sync_hold[0];
                        next_phase       = PH_WAIT_Y;
                    end
                end
                default: next_phase = PH_WAIT_Y;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pclk_d        <= 1'b0;
            phase         <= PH_WAIT_Y;
            y_hold        <= '0;
            sync_hold     <= '1;
            pix_valid     <= 1'b0;
            pix_ch0       <= '0;
            pix_ch1       <= '0;
            pix_ch2       <= '0;
            pix_fmt       <= vpi_pkg::FMT_NONE;
            pix_hsync_n   <= 1'b1;
            pix_vsync_n   <= 1'b1;
            pix_blank_n   <= 1'b1;
            ext_sync_only <= 1'b0;
        end else begin
            pclk_d        <= next_pclk_d;
            phase         <= next_phase;
            y_hold        <= next_y_hold;
            sync_hold     <= next_sync_hold;
            pix_valid     <= next_pix_valid;
            pix_ch0       <= next_pix_ch0;
            pix_ch1       <= next_pix_ch1;
            pix_ch2       <= next_pix_ch2;
            pix_fmt       <= next_pix_fmt;
            pix_hsync_n   <= next_pix_hsync_n;
            pix_vsync_n   <= next_pix_vsync_n;
            pix_blank_n   <= next_pix_blank_n;
            ext_sync_only <= next_ext_sync_only;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence y_taken;
        y_cap && phase == PH_WAIT_Y;
    endsequence

    sequence c_taken;
        c_cap && phase == PH_WAIT_C;
    endsequence

    chk_mode_reset: assert property ($rose(rst_n) |-> mode == vpi_pkg::MODE_SD)
        else $error("mode not sd after reset");
    chk_mode_route: assert property (
        reg_wr && reg_addr == vpi_pkg::ADDR_INPUT_MODE
        && reg_wdata[vpi_pkg::MODE_LSB +: 3] == vpi_pkg::MODE_ED54
        |=> ##1 pix_fmt == vpi_pkg::FMT_ED54)
        else $error("mode write did not steer format");
    chk_sd_rgb_lanes: assert property (sdr_cap && rt_fmt == vpi_pkg::FMT_SD_RGB
        |=> pix_ch0 == $past(sd_s) && pix_ch1 == $past(luma_s)
            && pix_ch2 == $past(chroma_s))
        else $error("sd rgb lanes wrong");
    chk_sd16_swap: assert property (sdr_cap && rt_fmt == vpi_pkg::FMT_SD_YC16 && swap
        |=> pix_ch0 == $past(luma_s) && pix_ch1 == $past(chroma_s))
        else $error("sd 16-bit swap lanes wrong");
    chk_hd444_lanes: assert property (sdr_cap && rt_fmt == vpi_pkg::FMT_HD_YC444
        |=> pix_ch0 == $past(luma_s) && pix_ch1 == $past(sd_s)
            && pix_ch2 == $past(chroma_s))
        else $error("hd 4:4:4 lanes wrong");
    chk_ext_sync: assert property (mode == vpi_pkg::MODE_SD && sd_rgb
        |=> ext_sync_only)
        else $error("external sync flag missing");
    // the pair is looked at once its second half lands, a few source phases after the first
    chk_ddr_pair: assert property (y_taken ##[1:40] c_taken
        |=> pix_valid && pix_ch0 == $past(y_hold) && pix_ch1 == $past(luma_s))
        else $error("dual-rate pair lost");
    chk_ddr_rgb_ref: assert property (mode == vpi_pkg::MODE_HD_DDR && hd_rgb
        |=> !pix_valid && pix_fmt == vpi_pkg::FMT_REFUSED)
        else $error("rgb accepted at dual rate");
    chk_edge_select: assert property (y_taken
        |-> pclk_s != pclk_d && pclk_s == (edge_sel == vpi_pkg::EDGE_Y_RISE))
        else $error("luma taken on wrong edge");
    chk_sdr_edge: assert property (pix_valid && !$past(rt_ddr) |-> $past(pclk_rise))
        else $error("single-rate sample off the rising edge");
endmodule
`default_nettype wire

// file: hdl/vpi_pkg.sv
`default_nettype none
package vpi_pkg;
    // register offsets
    localparam logic [7:0] ADDR_INPUT_MODE = 8'h01;
    localparam logic [7:0] ADDR_HD_FORMAT  = 8'h33;
    localparam logic [7:0] ADDR_HD_CTRL    = 8'h35;
    localparam logic [7:0] ADDR_SD_RGB     = 8'h87;
    localparam logic [7:0] ADDR_SD_FORMAT  = 8'h88;
    localparam logic [7:0] ADDR_STATUS     = 8'hF8;
    // field positions
    localparam int MODE_LSB   = 4;
    localparam int SWAP_BIT   = 7;
    localparam int EDGE_LSB   = 1;
    localparam int HD_422_BIT = 6;
    localparam int HD_RGB_BIT = 1;
    localparam int SD_RGB_BIT = 7;
    localparam int SD_FMT_LSB = 3;
    localparam int STAT_EXT   = 7;
    localparam int STAT_REF   = 6;
    // reset values
    localparam logic [2:0] RST_MODE   = 3'h0;
    localparam logic [1:0] RST_EDGE   = 2'h0;
    localparam logic [1:0] RST_SD_FMT = 2'h0;
    localparam logic       RST_BIT    = 1'b0;
    // input mode codes
    localparam logic [2:0] MODE_SD      = 3'h0;
    localparam logic [2:0] MODE_HD_SDR  = 3'h1;
    localparam logic [2:0] MODE_HD_DDR  = 3'h2;
    localparam logic [2:0] MODE_SIM_SDR = 3'h3;
    localparam logic [2:0] MODE_SIM_DDR = 3'h4;
    localparam logic [2:0] MODE_ED54    = 3'h7;
    // dual-rate edge field value that puts luma on the rising edge
    localparam logic [1:0] EDGE_Y_RISE  = 2'h0;
    typedef enum logic [3:0] {
        FMT_NONE,
        FMT_SD_YC8,
        FMT_SD_YC16,
        FMT_SD_RGB,
        FMT_HD_YC16,
        FMT_HD_YC444,
        FMT_HD_RGB,
        FMT_HD_DDR8,
        FMT_ED54,
        FMT_REFUSED
    } fmt_t;
endpackage
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic          ref_clk, rst_n, reg_wr, reg_rd, pclk, pix_valid;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata, sd_b, y_b, c_b;
    logic [7:0]    pix_ch0, pix_ch1, pix_ch2, cap0, cap1, cap2;
    logic [4:0]    syncs;
    logic [2:0]    capsy;
    logic          pix_hsync_n, pix_vsync_n, pix_blank_n, ext_sync_only;
    vpi_pkg::fmt_t pix_fmt;
    int            errors = 0, n_compared = 0, cycles = 0, n_valid = 0, nv = 0;

    video_src u_src (.ref_clk(ref_clk), .primary_clock_input(pclk), .sd_pixel_bus(sd_b),
        .luma_pixel_bus(y_b), .chroma_pixel_bus(c_b), .syncs(syncs));
    video_pixel_input_router u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .primary_clock_input(pclk), .sd_pixel_bus(sd_b), .luma_pixel_bus(y_b),
        .chroma_pixel_bus(c_b), .sd_hsync_n(syncs[0]), .sd_vsync_n(syncs[1]),
        .prog_hsync_n(syncs[2]), .prog_vsync_n(syncs[3]), .prog_blank_n(syncs[4]),
        .pix_valid(pix_valid), .pix_ch0(pix_ch0), .pix_ch1(pix_ch1), .pix_ch2(pix_ch2),
        .pix_fmt(pix_fmt), .pix_hsync_n(pix_hsync_n), .pix_vsync_n(pix_vsync_n),
        .pix_blank_n(pix_blank_n), .ext_sync_only(ext_sync_only));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // the pulse is short, so the pixel is latched here for later comparison
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (pix_valid === 1'b1) begin
            cap0    <= pix_ch0;
            cap1    <= pix_ch1;
            cap2    <= pix_ch2;
            capsy   <= {pix_blank_n, pix_vsync_n, pix_hsync_n};
            n_valid <= n_valid + 1;
        end
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic sdr(input logic [7:0] s, input logic [7:0] y, input logic [7:0] c,
                       input logic [4:0] sy, input int v);
        u_src.pixel(s, y, c, sy);
        #1;
        nv += v;
        `CHK(n_valid, nv)
    endtask
    task automatic ddr(input logic [7:0] r, input logic [7:0] f, input int v);
        u_src.phase(1'b1, 8'h00, r, 8'h00, 5'b01101);
        u_src.phase(1'b0, 8'h00, f, 8'h00, 5'b01101);
        #1;
        nv += v;
        `CHK(n_valid, nv)
    endtask
    task automatic got(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2,
                       input logic [2:0] esy, input vpi_pkg::fmt_t ef, input int nch);
        `CHK(cap0, e0)
        if (nch > 1) `CHK(cap1, e1)
        if (nch > 2) `CHK(cap2, e2)
        `CHK(capsy, esy)
        `CHK(pix_fmt, ef)
    endtask

    initial begin
        rst_n     = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(vpi_pkg::ADDR_INPUT_MODE, 8'h00);
        rd(8'h55, 8'h00);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b10110, 1);
        got(8'h5A, 8'h00, 8'h00, 3'b110, vpi_pkg::FMT_SD_YC8, 1);
        wr(vpi_pkg::ADDR_INPUT_MODE, 8'h80);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b10110, 1);
        got(8'hA5, 8'h00, 8'h00, 3'b110, vpi_pkg::FMT_SD_YC8, 1);
        `CHK(ext_sync_only, 1'b0)
        wr(vpi_pkg::ADDR_SD_FORMAT, 8'h08);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b10110, 1);
        got(8'hA5, 8'h3C, 8'h00, 3'b110, vpi_pkg::FMT_SD_YC16, 2);
        `CHK(ext_sync_only, 1'b1)
        wr(vpi_pkg::ADDR_INPUT_MODE, 8'h00);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b10110, 1);
        got(8'h5A, 8'hA5, 8'h00, 3'b110, vpi_pkg::FMT_SD_YC16, 2);
        wr(vpi_pkg::ADDR_SD_RGB, 8'h80);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b10110, 1);
        got(8'h5A, 8'hA5, 8'h3C, 3'b110, vpi_pkg::FMT_SD_RGB, 3);
        rd(vpi_pkg::ADDR_STATUS, 8'h83);
        wr(vpi_pkg::ADDR_INPUT_MODE, 8'h10);
        wr(vpi_pkg::ADDR_HD_FORMAT, 8'h40);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b01101, 1);
        got(8'hA5, 8'h3C, 8'h00, 3'b011, vpi_pkg::FMT_HD_YC16, 2);
        wr(vpi_pkg::ADDR_HD_FORMAT, 8'h00);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b01101, 1);
        got(8'hA5, 8'h5A, 8'h3C, 3'b011, vpi_pkg::FMT_HD_YC444, 3);
        wr(vpi_pkg::ADDR_HD_CTRL, 8'h02);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b01101, 1);
        got(8'h5A, 8'hA5, 8'h3C, 3'b011, vpi_pkg::FMT_HD_RGB, 3);
        wr(vpi_pkg::ADDR_INPUT_MODE, 8'h20);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b01101, 0);
        `CHK(pix_fmt, vpi_pkg::FMT_REFUSED)
        wr(vpi_pkg::ADDR_HD_CTRL, 8'h00);
        wr(vpi_pkg::ADDR_HD_FORMAT, 8'h40);
        ddr(8'h11, 8'h22, 1);
        got(8'h11, 8'h22, 8'h00, 3'b011, vpi_pkg::FMT_HD_DDR8, 3);
        // luma moves to the falling edge; the first rising byte has no partner
        wr(vpi_pkg::ADDR_INPUT_MODE, 8'h22);
        ddr(8'h33, 8'h44, 0);
        ddr(8'h55, 8'h66, 1);
        got(8'h44, 8'h55, 8'h00, 3'b011, vpi_pkg::FMT_HD_DDR8, 3);
        wr(vpi_pkg::ADDR_INPUT_MODE, 8'h30);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b01101, 0);
        `CHK(pix_fmt, vpi_pkg::FMT_NONE)
        wr(vpi_pkg::ADDR_INPUT_MODE, 8'h70);
        sdr(8'h5A, 8'hA5, 8'h3C, 5'b01101, 1);
        got(8'hA5, 8'h00, 8'h00, 3'b011, vpi_pkg::FMT_ED54, 1);
        rd(vpi_pkg::ADDR_INPUT_MODE, 8'h70);
        wrap_up();
    end
endmodule
`default_nettype wire

// file: tb/video_src.sv
`default_nettype none
module video_src (
    // clock
    input  wire logic       ref_clk,
    // pins toward the router
    output logic            primary_clock_input,
    output logic      [7:0] sd_pixel_bus,
    output logic      [7:0] luma_pixel_bus,
    output logic      [7:0] chroma_pixel_bus,
    output logic      [4:0] syncs
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        primary_clock_input = 1'b0;
        sd_pixel_bus        = 8'h00;
        luma_pixel_bus      = 8'h00;
        chroma_pixel_bus    = 8'h00;
        syncs               = 5'h1F;
    end
    // one clock phase of four ref_clk cycles, four times the one-cycle minimum the router needs
    task automatic phase(input logic lvl, input logic [7:0] s, input logic [7:0] y,
                         input logic [7:0] c, input logic [4:0] sy);
        primary_clock_input <= lvl;
        sd_pixel_bus        <= s;
        luma_pixel_bus      <= y;
        chroma_pixel_bus    <= c;
        syncs               <= sy;
        repeat (4) @(posedge ref_clk);
    endtask
    // buses show inverted junk while low, so a late sample cannot pass
    task automatic pixel(input logic [7:0] s, input logic [7:0] y, input logic [7:0] c,
                         input logic [4:0] sy);
        phase(1'b1, s, y, c, sy);
        phase(1'b0, ~s, ~y, ~c, ~sy);
    endtask
endmodule
`default_nettype wire
